//--- ecppe_engine.sv
// Parallel port engine: mode decode, forward write and backward read handshakes, expansion.
// Functional notes
// - Forward write puts byte on data, tag on AFD in ECP mode, strobes once BUSY low.
// - Parallel-port FIFO mode ends the strobe itself without waiting for BUSY.
// - ECP mode drops strobe after BUSY high, changes lines after BUSY low.
// - Standard mode: software writes, open-drain controls, forward, FIFO empty, data readback.
// - Bidirectional mode: software cycles, FIFO empty, push-pull controls.
// - Parallel-port FIFO mode: hardware strobe, forced forward, push-pull controls.
// - ECP mode: direction bit steers FIFO, hardware handshakes, push-pull.
// - EPP mode: alternate registers at first offsets; otherwise acts as bidirectional mode.
// - Test mode: FIFO via test port only, no peripheral cycles.
// - Capability configuration registers accessible only in configuration mode.
// - Backward, FIFO not full: read cycle; BUSY high pushes data, low is command.
// - Command with top bit one discarded; top bit zero kept as run count.
// - Byte after a run count is data, pushed count plus one times.
// - Backward in ECP mode, test port reads drain FIFO; other port reads do not.
// - DMA enabled and service bit clear: backward DMA requests, ECP mode only.
// - Backward cycle starts with AFD low; peripheral presents BUSY and byte.
// - On ACK the device raises AFD, latches data after ACK release, lowers AFD.
// - Each expanded push checks FIFO full and waits while full.
// - Leaving FIFO modes cancels DMA requests and abandons expansion.
// - Forward empty flag sets only when the last byte's cycle completes.
// - No zero-wait-state answer during DMA transfers.
// - ECP mode AFD follows tag; parallel-port FIFO mode follows a control bit.
// - Forward with FIFO not empty: pop one byte and start a write cycle.
`timescale 1ns/1ps
module ecppe_engine
    import ecppe_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] mode_i,
    input  wire logic       dir_i,
    input  wire logic       dma_en_i,
    input  wire logic       serv_intr_i,
    input  wire logic       sw_strobe_i,
    input  wire logic       sw_autofd_i,
    input  wire logic       sw_init_i,
    input  wire logic       sw_selin_i,
    input  wire logic       data_wr_i,
    input  wire logic [7:0] data_wdata_i,
    input  wire logic       fifo_wr_i,
    input  wire logic       fifo_wr_cmd_i,
    input  wire logic [7:0] fifo_wdata_i,
    input  wire logic       test_fifo_rd_i,
    input  wire logic       other_fifo_rd_i,
    input  wire logic       dma_ack_i,
    input  wire logic       busy_i,
    input  wire logic       ack_n_i,
    input  wire logic [7:0] pd_i,
    output logic      [7:0] pd_o,
    output logic            pd_oe_o,
    output logic            strobe_n_o,
    output logic            strobe_n_oe_o,
    output logic            autofd_n_o,
    output logic            autofd_n_oe_o,
    output logic            init_n_o,
    output logic            init_n_oe_o,
    output logic            selin_n_o,
    output logic            selin_n_oe_o,
    output logic      [7:0] data_rdata_o,
    output logic      [7:0] fifo_rdata_o,
    output logic            fifo_full_o,
    output logic            fifo_empty_o,
    output logic            dma_req_o,
    output logic            zero_wait_o,
    output logic            epp_regs_o,
    output logic            cfg_access_o
);
    typedef enum logic [2:0] {
        ECPPE_IDLE, ECPPE_WR_SETUP, ECPPE_WR_STB, ECPPE_WR_HOLD,
        ECPPE_RD_WAIT_ACK, ECPPE_RD_WAIT_REL, ECPPE_RD_PUSH
    } ecppe_state_t;

    ecppe_state_t     state_ff;
    ecppe_state_t     nxt_state;
    logic [7:0]       data_reg_ff;
    logic [7:0]       pd_ff;
    logic             tag_ff;
    logic             strobe_ff;
    logic             autofd_ff;
    logic             rlc_pend_ff;
    logic [7:0]       rlc_ff;
    logic [2:0]       mode_ff;
    logic             fwd_empty_ff;
    logic [7:0]       fifo_rdata_ff;
    logic [8:0]       pop_data;
    logic             fifo_empty;
    logic [4:0]       fifo_count;

    // Mode decode.
    wire mode_std   = (mode_i == ECPPE_MODE_STD);
    wire mode_ppf   = (mode_i == ECPPE_MODE_PPFIFO);
    wire mode_ecp   = (mode_i == ECPPE_MODE_ECP);
    wire mode_test  = (mode_i == ECPPE_MODE_TEST);
    wire hw_mode    = mode_ppf || mode_ecp;
    wire fifo_mode  = hw_mode || mode_test;
    // Standard and parallel-port FIFO modes force the forward direction.
    wire eff_dir    = (mode_std || mode_ppf) ? 1'b0 : dir_i;
    // The FIFO is held empty outside FIFO modes and on any mode change.
    wire flush      = !fifo_mode || (mode_ff != mode_i);
    wire fwd_run    = hw_mode && !eff_dir;
    wire bwd_run    = mode_ecp && eff_dir;
    wire fifo_full;

    // Host-side pushes go to the FIFO forward or in test mode; the tag marks command bytes.
    wire host_push  = fifo_wr_i && ((fifo_mode && !eff_dir) || mode_test);
    wire eng_push   = (state_ff == ECPPE_RD_PUSH) && !fifo_full;
    wire push       = eng_push || host_push;
    wire [8:0] push_data = eng_push ? {1'b0, pd_ff} : {fifo_wr_cmd_i, fifo_wdata_i};
    // Among host reads only test-port ones drain it, backward in ECP mode or in test mode; backward DMA acks also pop.
    wire host_pop   = test_fifo_rd_i && ((bwd_run) || mode_test) && !other_fifo_rd_i;
    wire eng_pop    = fwd_run && (state_ff == ECPPE_IDLE) && !fifo_empty;
    wire pop        = host_pop || eng_pop || (dma_ack_i && bwd_run);

    ecppe_fifo u_fifo (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .flush_i     (flush),
        .push_i      (push),
        .push_data_i (push_data),
        .pop_i       (pop),
        .pop_data_o  (pop_data),
        .full_o      (fifo_full),
        .empty_o     (fifo_empty),
        .count_o     (fifo_count)
    );

    // Handshake sequencer; test mode never starts a peripheral cycle.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ECPPE_IDLE: begin
                if (eng_pop) begin
                    nxt_state = ECPPE_WR_SETUP;
                end else if (bwd_run && (!fifo_full || rlc_pend_ff)) begin
                    nxt_state = ECPPE_RD_WAIT_ACK;
                end
            end
            ECPPE_WR_SETUP: if (!busy_i) nxt_state = ECPPE_WR_STB;
            ECPPE_WR_STB: begin
                if (mode_ppf) begin
                    nxt_state = ECPPE_IDLE;
                end else if (busy_i) begin
                    nxt_state = ECPPE_WR_HOLD;
                end
            end
            ECPPE_WR_HOLD:     if (!busy_i) nxt_state = ECPPE_IDLE;
            ECPPE_RD_WAIT_ACK: if (!ack_n_i) nxt_state = ECPPE_RD_WAIT_REL;
            ECPPE_RD_WAIT_REL: if (ack_n_i) nxt_state = ECPPE_IDLE;
            ECPPE_RD_PUSH: begin
                if (!fifo_full && (rlc_ff == ECPPE_RLC_ZERO)) nxt_state = ECPPE_IDLE;
            end
            default: nxt_state = ECPPE_IDLE;
        endcase
        // Leaving the FIFO modes abandons any cycle in flight.
        if (!hw_mode) nxt_state = ECPPE_IDLE;
    end

    // A completed read classifies the latched byte.
    wire rd_done  = (state_ff == ECPPE_RD_WAIT_REL) && ack_n_i && hw_mode;
    wire rd_data  = busy_i || rlc_pend_ff;
    wire rd_rlc   = !rd_data && !pd_i[ECPPE_CMD_BIT];

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff    <= ECPPE_IDLE;
            mode_ff     <= ECPPE_MODE_STD;
            rlc_pend_ff <= 1'b0;
            rlc_ff      <= ECPPE_RLC_ZERO;
        end else begin
            mode_ff  <= mode_i;
            state_ff <= (rd_done && rd_data) ? ECPPE_RD_PUSH : nxt_state;
            if (!hw_mode || flush) begin
                rlc_pend_ff <= 1'b0;
                rlc_ff      <= ECPPE_RLC_ZERO;
            end else if (rd_done) begin
                rlc_pend_ff <= rd_rlc;
                if (rd_rlc) rlc_ff <= pd_i;
            end else if (eng_push && (rlc_ff != ECPPE_RLC_ZERO)) begin
                rlc_ff <= rlc_ff - ECPPE_RLC_ONE;
            end
        end
    end

    // Pins and latched data.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_reg_ff  <= ECPPE_BYTE_ZERO;
            pd_ff        <= ECPPE_BYTE_ZERO;
            tag_ff       <= 1'b0;
            fwd_empty_ff <= 1'b1;
            fifo_rdata_ff<= ECPPE_BYTE_ZERO;
        end else begin
            if (data_wr_i) data_reg_ff <= data_wdata_i;
            if (eng_pop) begin
                pd_ff  <= pop_data[7:0];
                tag_ff <= pop_data[ECPPE_TAG_BIT];
            end else if (rd_done) begin
                pd_ff <= pd_i;
            end
            if (host_pop) fifo_rdata_ff <= pop_data[7:0];
            // Empty only once the FIFO is drained and the last cycle has ended.
            fwd_empty_ff <= fifo_empty && (state_ff == ECPPE_IDLE) && !push;
        end
    end

    wire sw_mode   = !hw_mode;
    wire wr_active = (state_ff == ECPPE_WR_STB);
    // Backward: AFD low at start, high while ACK is asserted.
    wire rd_afd    = (state_ff == ECPPE_RD_WAIT_REL);
    // ECP tag is set for command bytes, driving AFD low; PP FIFO follows the control bit.
    wire fwd_afd_n = mode_ecp ? !tag_ff : sw_autofd_i;
    assign strobe_n_o    = sw_mode ? sw_strobe_i : !wr_active;
    assign autofd_n_o    = sw_mode ? sw_autofd_i : (eff_dir ? rd_afd : fwd_afd_n);
    assign init_n_o      = sw_init_i;
    assign selin_n_o     = sw_selin_i;
    // Standard mode controls are open-drain: enabled only while pulling low.
    assign strobe_n_oe_o = mode_std ? !strobe_n_o : 1'b1;
    assign autofd_n_oe_o = mode_std ? !autofd_n_o : 1'b1;
    assign init_n_oe_o   = mode_std ? !init_n_o   : 1'b1;
    assign selin_n_oe_o  = mode_std ? !selin_n_o  : 1'b1;
    assign pd_o          = hw_mode ? pd_ff : data_reg_ff;
    assign pd_oe_o       = !eff_dir;
    // Standard mode and a clear direction bit read back the written value; a set direction bit outside standard mode reads the pins.
    assign data_rdata_o  = (mode_std || !dir_i) ? data_reg_ff : pd_i;
    assign fifo_rdata_o  = fifo_rdata_ff;
    assign fifo_full_o   = fifo_full;
    assign fifo_empty_o  = fwd_run ? fwd_empty_ff : fifo_empty;
    // Backward DMA only in ECP mode, dropped on any mode change.
    assign dma_req_o     = bwd_run && dma_en_i && !serv_intr_i && !fifo_empty && !flush;
    assign zero_wait_o   = !dma_ack_i && !mode_ff[2] && 1'b0;
    assign epp_regs_o    = (mode_i == ECPPE_MODE_EPP);
    assign cfg_access_o  = (mode_i == ECPPE_MODE_CFG);

    AST_WR_AFTER_BUSY_LOW: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $rose(state_ff == ECPPE_WR_STB) |-> !$past(busy_i))
        else $error("Strobe asserted while busy was high.");
    AST_PPF_SHORT_STB: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state_ff == ECPPE_WR_STB) && mode_ppf |=> !wr_active)
        else $error("Strobe held too long in parallel port FIFO mode.");
    AST_ECP_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state_ff == ECPPE_WR_HOLD) && mode_ecp && busy_i |=> $stable(pd_ff))
        else $error("Data changed before busy returned low.");
    AST_STD_FWD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        mode_std |-> pd_oe_o && fifo_empty)
        else $error("Standard mode not forward or FIFO not empty.");
    AST_TEST_NO_CYCLE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        mode_test |=> state_ff == ECPPE_IDLE)
        else $error("Peripheral cycle in test mode.");
    AST_FULL_NO_READ: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (state_ff == ECPPE_IDLE) && fifo_full && !rlc_pend_ff |=> state_ff != ECPPE_RD_WAIT_ACK)
        else $error("Read cycle started with FIFO full.");
    AST_DMA_ECP_ONLY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        dma_req_o |-> mode_ecp && dir_i && !serv_intr_i)
        else $error("DMA request outside backward ECP mode.");
    AST_NO_ZWS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        dma_ack_i |-> !zero_wait_o)
        else $error("Zero wait state during DMA.");
endmodule : ecppe_engine

//--- ecppe_fifo.sv
// Sixteen-entry FIFO with flush, count and show-ahead output register.
`timescale 1ns/1ps
module ecppe_fifo
    import ecppe_pkg::*;
(
    input  wire logic                   ref_clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   flush_i,
    input  wire logic                   push_i,
    input  wire logic [ECPPE_ENT_W-1:0] push_data_i,
    input  wire logic                   pop_i,
    output logic      [ECPPE_ENT_W-1:0] pop_data_o,
    output logic                        full_o,
    output logic                        empty_o,
    output logic      [ECPPE_CNT_W-1:0] count_o
);
    logic [ECPPE_PTR_W-1:0] wr_ptr_ff;
    logic [ECPPE_PTR_W-1:0] rd_ptr_ff;
    logic [ECPPE_CNT_W-1:0] cnt_ff;
    logic [ECPPE_PTR_W-1:0] nxt_rd_ptr;
    logic [ECPPE_ENT_W-1:0] mem_rd;
    logic [ECPPE_ENT_W-1:0] byp_ff;
    logic                   byp_sel_ff;
    wire                    do_push = push_i && !full_o;
    wire                    do_pop  = pop_i && !empty_o;

    // Reading ahead at the next pointer keeps the head entry visible without a bubble.
    assign nxt_rd_ptr = do_pop ? rd_ptr_ff + ECPPE_PTR_ONE : rd_ptr_ff;
    assign full_o     = (cnt_ff == ECPPE_FIFO_FULL);
    assign empty_o    = (cnt_ff == ECPPE_CNT_ZERO);
    assign count_o    = cnt_ff;
    // A push to the address being read ahead would otherwise show the stale word for a cycle.
    assign pop_data_o = byp_sel_ff ? byp_ff : mem_rd;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            byp_sel_ff <= 1'b0;
            byp_ff     <= ECPPE_ENT_ZERO;
        end else begin
            byp_sel_ff <= do_push && (wr_ptr_ff == nxt_rd_ptr);
            byp_ff     <= push_data_i;
        end
    end

    ecppe_mem u_mem (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (do_push),
        .wr_addr_i (wr_ptr_ff),
        .wr_data_i (push_data_i),
        .rd_addr_i (nxt_rd_ptr),
        .rd_data_o (mem_rd)
    );

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= ECPPE_CNT_ZERO;
        end else if (flush_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= ECPPE_CNT_ZERO;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + ECPPE_PTR_ONE;
            end
            rd_ptr_ff <= nxt_rd_ptr;
            if (do_push && !do_pop) begin
                cnt_ff <= cnt_ff + ECPPE_CNT_ONE;
            end else if (do_pop && !do_push) begin
                cnt_ff <= cnt_ff - ECPPE_CNT_ONE;
            end
        end
    end
endmodule : ecppe_fifo

//--- ecppe_mem.sv
// Byte storage of the port FIFO with registered read data.
`timescale 1ns/1ps
module ecppe_mem
    import ecppe_pkg::*;
(
    input  wire logic                   ref_clk_i,
    input  wire logic                   wr_en_i,
    input  wire logic [ECPPE_PTR_W-1:0] wr_addr_i,
    input  wire logic [ECPPE_ENT_W-1:0] wr_data_i,
    input  wire logic [ECPPE_PTR_W-1:0] rd_addr_i,
    output logic      [ECPPE_ENT_W-1:0] rd_data_o
);
    logic [ECPPE_ENT_W-1:0] mem_ff [ECPPE_FIFO_DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_ff[rd_addr_i];
    end
endmodule : ecppe_mem

//--- ecppe_periph.sv
// Behavioural peripheral that answers forward writes and backward reads.
`timescale 1ns/1ps
module ecppe_periph (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       slow_i,
    input  wire logic       strobe_n_i,
    input  wire logic       autofd_n_i,
    input  wire logic [7:0] pd_i,
    output logic            busy_o,
    output logic            ack_n_o,
    output logic      [7:0] pd_o
);
    // Forward log entries hold the AFD level in bit 8; backward entries carry BUSY there: one marks data, zero a command.
    logic [8:0] fwd_log [$];
    logic [8:0] bwd_q [$];
    int         dly;
    int         st;
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o  <= 1'b0;
            ack_n_o <= 1'b1;
            pd_o    <= 8'h5A;
            st      <= 0;
            dly     <= 0;
        end else if (dly != 0) begin
            dly <= dly - 1;
        end else begin
            case (st)
                0: if (!strobe_n_i) begin
                    fwd_log.push_back({autofd_n_i, pd_i});
                    busy_o <= 1'b1;
                    st     <= 1;
                    dly    <= slow_i ? 4 : 0;
                end else if (!autofd_n_i && bwd_q.size() != 0) begin
                    busy_o <= bwd_q[0][8];
                    pd_o   <= bwd_q[0][7:0];
                    st     <= 2;
                end
                1: if (strobe_n_i) begin
                    busy_o <= 1'b0;
                    st     <= 0;
                end
                2: begin
                    ack_n_o <= 1'b0;
                    st      <= 3;
                    dly     <= slow_i ? 3 : 0;
                end
                3: if (autofd_n_i) begin
                    ack_n_o <= 1'b1;
                    st      <= 4;
                end
                // The byte is inverted once released, so a late latch reads garbage.
                4: if (!autofd_n_i) begin
                    pd_o <= ~pd_o;
                    void'(bwd_q.pop_front());
                    st   <= 0;
                end
                default: st <= 0;
            endcase
        end
    end
endmodule : ecppe_periph

//--- ecppe_pkg.sv
// Package with the mode codes, field positions and sizes of the parallel port engine.
package ecppe_pkg;
    localparam logic [2:0] ECPPE_MODE_STD     = 3'h0;
    localparam logic [2:0] ECPPE_MODE_BIDIR   = 3'h1;
    localparam logic [2:0] ECPPE_MODE_PPFIFO  = 3'h2;
    localparam logic [2:0] ECPPE_MODE_ECP     = 3'h3;
    localparam logic [2:0] ECPPE_MODE_EPP     = 3'h4;
    localparam logic [2:0] ECPPE_MODE_TEST    = 3'h6;
    localparam logic [2:0] ECPPE_MODE_CFG     = 3'h7;
    localparam int         ECPPE_FIFO_DEPTH   = 16;
    localparam int         ECPPE_PTR_W        = 4;
    localparam int         ECPPE_CNT_W        = 5;
    localparam int         ECPPE_ENT_W        = 9;
    localparam int         ECPPE_TAG_BIT      = 8;
    localparam int         ECPPE_CMD_BIT      = 7;
    localparam logic [4:0] ECPPE_FIFO_FULL    = 5'h10;
    localparam logic [4:0] ECPPE_CNT_ZERO     = 5'h00;
    localparam logic [4:0] ECPPE_CNT_ONE      = 5'h01;
    localparam logic [3:0] ECPPE_PTR_ONE      = 4'h1;
    localparam logic [7:0] ECPPE_RLC_ONE      = 8'h01;
    localparam logic [7:0] ECPPE_RLC_ZERO     = 8'h00;
    localparam logic [7:0] ECPPE_BYTE_ZERO    = 8'h00;
    localparam logic [8:0] ECPPE_ENT_ZERO     = 9'h000;
endpackage : ecppe_pkg

//--- tb_ecp_parallel_port_engine.sv
// Self-checking bench of the parallel port engine against the peripheral model.
`timescale 1ns/1ps
module tb_ecp_parallel_port_engine;
    import ecppe_pkg::*;
    localparam logic [6:0] MROWS [6] = '{7'h08, 7'h14, 7'h2C, 7'h34, 7'h46, 7'h71};
    localparam logic [8:0] FROWS [4] = '{9'h055, 9'h1AA, 9'h000, 9'h1FF};
    logic       ref_clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [2:0] mode_i = ECPPE_MODE_STD;
    logic       dir_i = 1'b0;
    logic       dma_en_i = 1'b0;
    logic       serv_intr_i = 1'b1;
    logic       sw_autofd_i = 1'b1;
    logic       data_wr_i = 1'b0;
    logic [7:0] data_wdata_i = 8'h00;
    logic       fifo_wr_i = 1'b0;
    logic       fifo_wr_cmd_i = 1'b0;
    logic [7:0] fifo_wdata_i = 8'h00;
    logic       test_fifo_rd_i = 1'b0;
    logic       other_fifo_rd_i = 1'b0;
    logic       slow = 1'b0;
    logic [7:0] pd_o, data_rdata_o, fifo_rdata_o, per_pd, pd_w;
    logic       pd_oe_o, strobe_n_o, strobe_n_oe_o, autofd_n_o, autofd_n_oe_o;
    logic       fifo_full_o, fifo_empty_o, dma_req_o, zero_wait_o, epp_regs_o;
    logic       cfg_access_o, per_busy, per_ack_n, stb_w, afd_w;
    int         err_total = 0;
    int         tests_run = 0;
    int         cyc = 0;
    // Open-drain controls float high through the cable pull-ups.
    assign pd_w  = pd_oe_o ? pd_o : per_pd;
    assign stb_w = strobe_n_oe_o ? strobe_n_o : 1'b1;
    assign afd_w = autofd_n_oe_o ? autofd_n_o : 1'b1;
    ecppe_engine u_ecppe_engine (
        .ref_clk_i, .reset_i, .mode_i, .dir_i, .dma_en_i, .serv_intr_i,
        .sw_strobe_i(1'b1), .sw_autofd_i, .sw_init_i(1'b1), .sw_selin_i(1'b1),
        .data_wr_i, .data_wdata_i, .fifo_wr_i, .fifo_wr_cmd_i, .fifo_wdata_i,
        .test_fifo_rd_i, .other_fifo_rd_i, .dma_ack_i(1'b0), .busy_i(per_busy),
        .ack_n_i(per_ack_n), .pd_i(pd_w), .pd_o, .pd_oe_o, .strobe_n_o, .strobe_n_oe_o,
        .autofd_n_o, .autofd_n_oe_o, .init_n_o(), .init_n_oe_o(), .selin_n_o(),
        .selin_n_oe_o(), .data_rdata_o, .fifo_rdata_o, .fifo_full_o, .fifo_empty_o,
        .dma_req_o, .zero_wait_o, .epp_regs_o, .cfg_access_o);
    ecppe_periph u_ecppe_periph (
        .ref_clk_i, .reset_i, .slow_i(slow), .strobe_n_i(stb_w), .autofd_n_i(afd_w),
        .pd_i(pd_w), .busy_o(per_busy), .ack_n_o(per_ack_n), .pd_o(per_pd));
    initial forever #2 ref_clk_i = ~ref_clk_i;
    task automatic summarize();
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc_n(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc_n
    task automatic push(input logic c, input logic [7:0] d);
        @(posedge ref_clk_i);
        fifo_wr_i     <= 1'b1;
        fifo_wr_cmd_i <= c;
        fifo_wdata_i  <= d;
        @(posedge ref_clk_i);
        fifo_wr_i <= 1'b0;
    endtask : push
    task automatic pop_chk(input logic [7:0] exp);
        @(posedge ref_clk_i);
        test_fifo_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        test_fifo_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk("fifo_rdata_o", {1'b0, fifo_rdata_o}, {1'b0, exp});
    endtask : pop_chk
    task automatic wait_log(input int n);
        for (int i = 0; i < 400 && u_ecppe_periph.fwd_log.size() < n; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask : wait_log
    task automatic wait_empty(input logic v);
        for (int i = 0; i < 400 && fifo_empty_o !== v; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask : wait_empty
    task automatic set_mode(input logic [2:0] m, input logic d);
        @(posedge ref_clk_i);
        mode_i <= m;
        dir_i  <= d;
        cyc_n(3);
        #1;
    endtask : set_mode
    initial begin
        cyc_n(4);
        reset_i <= 1'b0;
        cyc_n(1);
        #1;
        chk("fifo_empty_o", fifo_empty_o, 1'b1);
        chk("zero_wait_o", zero_wait_o, 1'b0);
        for (int r = 0; r < 6; r++) begin
            set_mode(MROWS[r][6:4], 1'b1);
            if (MROWS[r][6:4] != ECPPE_MODE_CFG) begin
                chk("pd_oe_o", pd_oe_o, MROWS[r][3]);
                chk("strobe_n_oe_o", strobe_n_oe_o, MROWS[r][2]);
            end
            chk("epp_regs_o", epp_regs_o, MROWS[r][1]);
            chk("cfg_access_o", cfg_access_o, MROWS[r][0]);
        end
        set_mode(ECPPE_MODE_STD, 1'b0);
        data_wr_i    <= 1'b1;
        data_wdata_i <= 8'hC3;
        @(posedge ref_clk_i);
        data_wr_i <= 1'b0;
        cyc_n(2);
        #1;
        chk("data_rdata_o", data_rdata_o, 8'hC3);
        set_mode(ECPPE_MODE_ECP, 1'b0);
        slow <= 1'b1;
        // Back-to-back pushes keep the FIFO filling while the engine's first cycle is still open.
        for (int r = 0; r < 4; r++) begin
            @(posedge ref_clk_i);
            fifo_wr_i     <= 1'b1;
            fifo_wr_cmd_i <= FROWS[r][8];
            fifo_wdata_i  <= FROWS[r][7:0];
        end
        @(posedge ref_clk_i);
        fifo_wr_i <= 1'b0;
        wait_log(4);
        chk("fifo_empty_o", fifo_empty_o, 1'b0);
        wait_empty(1'b1);
        for (int r = 0; r < 4; r++) begin
            chk("fwd", u_ecppe_periph.fwd_log[r], {~FROWS[r][8], FROWS[r][7:0]});
        end
        set_mode(ECPPE_MODE_PPFIFO, 1'b1);
        for (int i = 0; i < 2; i++) begin
            sw_autofd_i <= i[0];
            push(~i[0], 8'h96 ^ i[7:0]);
            wait_log(5 + i);
            chk("ppfifo", u_ecppe_periph.fwd_log[4 + i], {i[0], 8'h96 ^ i[7:0]});
        end
        wait_empty(1'b1);
        set_mode(ECPPE_MODE_TEST, 1'b0);
        push(1'b0, 8'h3E);
        cyc_n(10);
        chk("log size", u_ecppe_periph.fwd_log.size(), 9'h006);
        pop_chk(8'h3E);
        set_mode(ECPPE_MODE_ECP, 1'b1);
        slow <= 1'b0;
        u_ecppe_periph.bwd_q = '{9'h111, 9'h085, 9'h002, 9'h03C, 9'h177};
        for (int i = 0; i < 400 && u_ecppe_periph.bwd_q.size() != 0; i++) cyc_n(1);
        cyc_n(12);
        dma_en_i <= 1'b1;
        cyc_n(2);
        #1;
        chk("dma_req_o", dma_req_o, 1'b0);
        serv_intr_i <= 1'b0;
        cyc_n(2);
        #1;
        chk("dma_req_o", dma_req_o, 1'b1);
        other_fifo_rd_i <= 1'b1;
        cyc_n(1);
        other_fifo_rd_i <= 1'b0;
        pop_chk(8'h11);
        for (int i = 0; i < 3; i++) pop_chk(8'h3C);
        set_mode(ECPPE_MODE_BIDIR, 1'b1);
        chk("dma_req_o", dma_req_o, 1'b0);
        chk("fifo_empty_o", fifo_empty_o, 1'b1);
        dma_en_i <= 1'b0;
        set_mode(ECPPE_MODE_ECP, 1'b1);
        u_ecppe_periph.bwd_q = '{9'h013, 9'h0E1, 9'h15A};
        for (int i = 0; i < 400 && fifo_full_o !== 1'b1; i++) cyc_n(1);
        cyc_n(10);
        chk("held byte", u_ecppe_periph.bwd_q.size(), 9'h001);
        for (int i = 0; i < 21; i++) begin
            wait_empty(1'b0);
            pop_chk(i < 20 ? 8'hE1 : 8'h5A);
        end
        summarize();
    end
endmodule : tb_ecp_parallel_port_engine
